// [design/sclk_ctrl.sv]
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sclk_ctrl
	import sclk_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	// Register port
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// CPU events
	input  wire logic        halt_i,
	input  wire logic        wake_i,
	input  wire logic        clr_wdt_i,
	input  wire logic        wdt_timeout_i,
	// Oscillator ticks and stability
	input  wire logic        fast_tick_i,
	input  wire logic        slow_tick_i,
	input  wire logic        fast_osc_stable_i,
	input  wire logic        slow_osc_stable_i,
	// Outputs
	output sclk_clk_s        clk_o,
	output sclk_ctl_s        ctl_o,
	output sclk_mode_e       mode_o,
	output logic             irq_o
);

	sclk_state_s q;
	sclk_state_s d;

	// Mask of divider counter bits that must all be one for a fast-side tick
	function automatic logic [5:0] div_mask(input logic fsel, input logic [2:0] sel);
		logic [5:0] m;
		m = 6'h00;
		if (fsel)
			m = 6'h00;
		else
		begin
			case (sel)
				3'h2:    m = 6'h3f;
				3'h3:    m = 6'h1f;
				3'h4:    m = 6'h0f;
				3'h5:    m = 6'h07;
				3'h6:    m = 6'h03;
				3'h7:    m = 6'h01;
				default: m = 6'h00;
			endcase
		end
		return m;
	endfunction

	logic       want_fast;
	logic       fast_ready;
	logic       slow_ready;
	logic       run_sys;
	logic       fast_en;
	logic       slow_en;
	logic       wdt_on;
	logic [5:0] mask;
	logic       div_hit;
	logic [SCLK_IRQ_W-1:0] ev;

	// Fast oscillator only stays on while it feeds, or is about to feed, the system
	assign want_fast = q.fast_sel | (q.div_sel > 3'h1);
	assign wdt_on    = (q.wdt_key == SCLK_WDT_KEY_ON);
	assign run_sys   = (q.mode == SCLK_RUN) || (q.mode == SCLK_IDLE_CLOCK_ON_MODE);
	// sub clock as source and no fast request turns the fast oscillator off
	assign fast_en   = run_sys && (q.src_fast || want_fast);
	assign slow_en   = (q.mode != SCLK_SLEEP_ALL_OFF_MODE) &&
			!((q.mode == SCLK_SLEEP_WDT_ON_MODE) && !wdt_on);
	assign fast_ready = fast_en & fast_osc_stable_i;
	assign slow_ready = slow_en & slow_osc_stable_i;
	assign mask      = div_mask(q.fast_sel, q.div_sel);
	assign div_hit   = ((q.div_cnt & mask) == mask);

	always_comb
	begin
		d = q;
		ev = '0;
		d.wdt_clear = 1'b0;
		d.rdata = 8'h00;
		d.fast_rdy_prev = fast_ready;
		d.slow_rdy_prev = slow_ready;

		if (fast_tick_i && fast_en)
			d.div_cnt = 6'(q.div_cnt + 6'h01);

		// Swap source only once the target runs; the old one keeps clocking meanwhile
		if (run_sys && want_fast && !q.src_fast && fast_ready)
		begin
			d.src_fast = 1'b1;
			ev[SCLK_IRQ_SWITCHED] = 1'b1;
		end
		else if (run_sys && !want_fast && q.src_fast && slow_ready)
		begin
			d.src_fast = 1'b0;
			ev[SCLK_IRQ_SWITCHED] = 1'b1;
		end

		if (fast_ready && !q.fast_rdy_prev)
			ev[SCLK_IRQ_FASTRDY] = 1'b1;
		if (slow_ready && !q.slow_rdy_prev)
			ev[SCLK_IRQ_SLOWRDY] = 1'b1;

		if (clr_wdt_i)
			d.power_down_flag = 1'b0;

		case (q.mode)
			SCLK_RUN:
			begin
				if (halt_i)
				begin
					ev[SCLK_IRQ_HALT] = 1'b1;
					d.wdt_clear = 1'b1;
					d.power_down_flag = 1'b1;
					d.tof = 1'b0;
					if (q.idle_on_halt)
						d.mode = q.keep_clk ? SCLK_IDLE_CLOCK_ON_MODE : SCLK_IDLE_CLOCK_OFF_MODE;
					else
						d.mode = wdt_on ? SCLK_SLEEP_WDT_ON_MODE : SCLK_SLEEP_ALL_OFF_MODE;
				end
			end
			SCLK_IDLE_CLOCK_OFF_MODE, SCLK_IDLE_CLOCK_ON_MODE, SCLK_SLEEP_ALL_OFF_MODE, SCLK_SLEEP_WDT_ON_MODE:
			begin
				if (wake_i || wdt_timeout_i)
					d.mode = SCLK_RUN;
			end
			default:
				d.mode = SCLK_RUN;
		endcase
		// A time-out in the same cycle as a halt still leaves its flag set
		if (wdt_timeout_i)
			d.tof = 1'b1;

		if (wr_i)
		begin
			if (addr_i == SCLK_OFF_MODE)
			begin
				d.div_sel = wdata_i[7:5];
				d.idle_on_halt = wdata_i[1];
				d.fast_sel = wdata_i[0];
			end
			else if (addr_i == SCLK_OFF_CTRL)
			begin
				d.keep_clk = wdata_i[7];
				d.rst_flags = wdata_i[2:0];
			end
			else if (addr_i == SCLK_OFF_WDTKEY)
				d.wdt_key = wdata_i[7:3];
			else if (addr_i == SCLK_OFF_IRQSTAT)
				d.irq_stat = q.irq_stat & ~wdata_i[SCLK_IRQ_W-1:0];
			else if (addr_i == SCLK_OFF_IRQMASK)
				d.irq_mask = wdata_i[SCLK_IRQ_W-1:0];
		end
		// A new event wins over a clear written in the same cycle
		d.irq_stat = d.irq_stat | ev;

		if (rd_i)
		begin
			if (addr_i == SCLK_OFF_MODE)
				d.rdata = {q.div_sel, 1'b0, slow_ready, fast_ready,
					q.idle_on_halt, q.fast_sel};
			else if (addr_i == SCLK_OFF_CTRL)
				d.rdata = {q.keep_clk, 4'h0, q.rst_flags};
			else if (addr_i == SCLK_OFF_WDTKEY)
				d.rdata = {q.wdt_key, 3'h0};
			else if (addr_i == SCLK_OFF_PWRSTAT)
				d.rdata = {6'h00, q.power_down_flag, q.tof};
			else if (addr_i == SCLK_OFF_IRQSTAT)
				d.rdata = {4'h0, q.irq_stat};
			else if (addr_i == SCLK_OFF_IRQMASK)
				d.rdata = {4'h0, q.irq_mask};
			else
				d.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			q.mode          <= SCLK_RUN;
			q.div_sel       <= SCLK_RST_DIV_SEL;
			q.idle_on_halt  <= SCLK_RST_IDLE;
			q.fast_sel      <= SCLK_RST_FASTSEL;
			q.keep_clk      <= SCLK_RST_KEEPCLK;
			q.rst_flags     <= 3'h0;
			q.wdt_key       <= SCLK_RST_WDT_KEY;
			q.power_down_flag           <= 1'b0;
			q.tof           <= 1'b0;
			q.irq_stat      <= '0;
			q.irq_mask      <= '0;
			q.div_cnt       <= 6'h00;
			q.src_fast      <= 1'b1;
			q.fast_rdy_prev <= 1'b0;
			q.slow_rdy_prev <= 1'b0;
			q.wdt_clear     <= 1'b0;
			q.rdata         <= 8'h00;
		end
		else if (ce_i)
			q <= d;
	end

	// System clock leaves as an enable pulse so the switch never makes a runt edge
	always_comb
	begin
		clk_o.sys_clk_en = run_sys &&
			(q.src_fast ? (fast_tick_i && fast_en && div_hit) : slow_tick_i);
		clk_o.fast_div16 = fast_en && fast_tick_i && (q.div_cnt[3:0] == 4'hf);
		clk_o.fast_div64 = fast_en && fast_tick_i && (q.div_cnt == 6'h3f);
		clk_o.sub_clk_en = slow_en && slow_tick_i;
		ctl_o.cpu_run     = (q.mode == SCLK_RUN);
		ctl_o.fast_osc_en = fast_en;
		ctl_o.slow_osc_en = slow_en;
		ctl_o.wdt_clear   = q.wdt_clear;
		ctl_o.wdt_run     = wdt_on && slow_en;
		ctl_o.wdt_key_bad = !wdt_on && (q.wdt_key != SCLK_WDT_KEY_OFF);
	end

	assign rdata_o = q.rdata;
	assign mode_o  = q.mode;
	assign irq_o   = |(q.irq_stat & q.irq_mask);

endmodule
`default_nettype wire

// [design/sclk_pkg.sv]
// How it works
// - Fast select low: divider codes 000/001 pick sub clock, 010..111 fast/64../2
// - Fast select high: undivided fast clock drives system, divider code ignored
// - Running from sub clock stops fast oscillator and its divide taps
// - Slow ready flag in bit 3, read only, set once slow oscillator stable
// - Fast ready flag in bit 2, read only, zero at power-on until stable
// - Halt enters idle when idle-on-halt bit 1 is one, else sleep
// - In idle, keep-clock bit 7 picks clock-on or clock-off idle
// - Halt to sleep with watchdog off: all clocks stop, watchdog cleared, stopped
// - Halt to sleep with watchdog on: system clock stops, watchdog cleared, runs
// - Clock-off idle: system clock stops, sub clock runs, watchdog cleared
// - Clock-on idle: system and sub clock run, CPU halted, watchdog cleared
// - Every halt sets power-down flag and clears watchdog time-out flag, unless a time-out arrives in the same cycle
// - Unimplemented mode bit 4 and control bits 6..3 read as zero
// - Switch to slow mode completes only after slow ready flag shows stable
// - Watchdog key 01010 means on, 10101 means off; picks sleep mode
// - Fast source is 8 MHz internal RC, sub clock 32 kHz internal RC
package sclk_pkg;

	localparam logic [2:0] SCLK_OFF_MODE    = 3'h0;
	localparam logic [2:0] SCLK_OFF_CTRL    = 3'h1;
	localparam logic [2:0] SCLK_OFF_WDTKEY  = 3'h2;
	localparam logic [2:0] SCLK_OFF_PWRSTAT = 3'h3;
	localparam logic [2:0] SCLK_OFF_IRQSTAT = 3'h4;
	localparam logic [2:0] SCLK_OFF_IRQMASK = 3'h5;

	localparam logic [2:0] SCLK_RST_DIV_SEL = 3'h7;
	localparam logic       SCLK_RST_IDLE    = 1'b1;
	localparam logic       SCLK_RST_FASTSEL = 1'b0;
	localparam logic       SCLK_RST_KEEPCLK = 1'b0;
	localparam logic [4:0] SCLK_WDT_KEY_ON  = 5'h0a;
	localparam logic [4:0] SCLK_WDT_KEY_OFF = 5'h15;
	localparam logic [4:0] SCLK_RST_WDT_KEY = 5'h0a;

	localparam int SCLK_FAST_OSC_HZ = 8000000;
	localparam int SCLK_SLOW_OSC_HZ = 32000;

	localparam int SCLK_IRQ_HALT     = 0;
	localparam int SCLK_IRQ_FASTRDY  = 1;
	localparam int SCLK_IRQ_SLOWRDY  = 2;
	localparam int SCLK_IRQ_SWITCHED = 3;
	localparam int SCLK_IRQ_W        = 4;

	typedef enum logic [4:0] {
		SCLK_RUN    = 5'h01,
		SCLK_IDLE_CLOCK_OFF_MODE  = 5'h02,
		SCLK_IDLE_CLOCK_ON_MODE  = 5'h04,
		SCLK_SLEEP_ALL_OFF_MODE = 5'h08,
		SCLK_SLEEP_WDT_ON_MODE = 5'h10
	} sclk_mode_e;

	typedef struct packed {
		logic sys_clk_en;
		logic fast_div16;
		logic fast_div64;
		logic sub_clk_en;
	} sclk_clk_s;

	typedef struct packed {
		logic cpu_run;
		logic fast_osc_en;
		logic slow_osc_en;
		logic wdt_clear;
		logic wdt_run;
		logic wdt_key_bad;
	} sclk_ctl_s;

	typedef struct packed {
		sclk_mode_e              mode;
		logic [2:0]              div_sel;
		logic                    idle_on_halt;
		logic                    fast_sel;
		logic                    keep_clk;
		logic [2:0]              rst_flags;
		logic [4:0]              wdt_key;
		logic                    power_down_flag;
		logic                    tof;
		logic [SCLK_IRQ_W-1:0]   irq_stat;
		logic [SCLK_IRQ_W-1:0]   irq_mask;
		logic [5:0]              div_cnt;
		logic                    src_fast;
		logic                    fast_rdy_prev;
		logic                    slow_rdy_prev;
		logic                    wdt_clear;
		logic [7:0]              rdata;
	} sclk_state_s;

endpackage

// [tb/scmc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module scmc_props
	import sclk_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       rst_b_i,
	// Inputs watched
	input wire logic       ce_i,
	input wire logic [2:0] addr_i,
	input wire logic       rd_i,
	input wire logic       halt_i,
	input wire logic       slow_tick_i,
	input wire logic       fast_osc_stable_i,
	input wire logic       slow_osc_stable_i,
	// Outputs watched
	input wire logic [7:0] rdata_o,
	input wire sclk_clk_s  clk_o,
	input wire sclk_ctl_s  ctl_o,
	input wire sclk_mode_e mode_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	wire logic run = (mode_o == SCLK_RUN);
	a_halt_enter: assert property (halt_i && ce_i && run |=> !run && ctl_o.wdt_clear &&
		!ctl_o.cpu_run) else $error("halt entry wrong");
	a_idle_clock_off_mode_clocks: assert property (mode_o == SCLK_IDLE_CLOCK_OFF_MODE |-> !clk_o.sys_clk_en &&
		clk_o.sub_clk_en == slow_tick_i) else $error("clock-off idle clocks wrong");
	a_idle_clock_on_mode_clocks: assert property (mode_o == SCLK_IDLE_CLOCK_ON_MODE |-> !ctl_o.cpu_run &&
		clk_o.sub_clk_en == slow_tick_i) else $error("clock-on idle clocks wrong");
	a_sleep_all_off_mode_off: assert property (mode_o == SCLK_SLEEP_ALL_OFF_MODE |-> !clk_o.sys_clk_en &&
		!clk_o.sub_clk_en && !ctl_o.wdt_run) else $error("all-off sleep wrong");
	a_sleep_wdt_on_mode_wdt: assert property (mode_o == SCLK_SLEEP_WDT_ON_MODE |-> !clk_o.sys_clk_en &&
		ctl_o.wdt_run) else $error("watchdog sleep wrong");
	a_taps_stop: assert property (!ctl_o.fast_osc_en |-> !clk_o.fast_div16 &&
		!clk_o.fast_div64) else $error("fast taps run while fast off");
	a_mode_unimpl: assert property ($past(rd_i && ce_i && addr_i == SCLK_OFF_MODE) |->
		!rdata_o[4]) else $error("mode bit 4 not zero");
	a_ctrl_unimpl: assert property ($past(rd_i && ce_i && addr_i == SCLK_OFF_CTRL) |->
		rdata_o[6:3] == 4'h0) else $error("control bits 6..3 not zero");
	a_ready_flags: assert property ($past(rd_i && ce_i && addr_i == SCLK_OFF_MODE && run) |->
		rdata_o[3:2] == {$past(slow_osc_stable_i), $past(fast_osc_stable_i && ctl_o.fast_osc_en)})
		else $error("ready flags wrong");
	c_idle_clock_off_mode: cover property (mode_o == SCLK_IDLE_CLOCK_OFF_MODE);
	c_sleep_all_off_mode: cover property (mode_o == SCLK_SLEEP_ALL_OFF_MODE);
	c_sleep_wdt_on_mode: cover property (mode_o == SCLK_SLEEP_WDT_ON_MODE);
endmodule
bind sclk_ctrl scmc_props u_props (.*);
`default_nettype wire

// [tb/scmc_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scmc_osc_model
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	// Enables
	input  wire logic fast_en_i,
	input  wire logic slow_en_i,
	// Ticks and stability
	output logic      fast_tick_o,
	output logic      slow_tick_o,
	output logic      fast_stable_o,
	output logic      slow_stable_o
);
	logic [3:0] fw_q;
	logic [3:0] sw_q;
	logic [4:0] ph_q;
	// Start-up delay: stable only after the enable has held eight cycles
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			fw_q <= 4'h0;
			sw_q <= 4'h0;
			ph_q <= 5'h00;
		end
		else
		begin
			fw_q <= !fast_en_i ? 4'h0 : fw_q + {3'h0, !fw_q[3]};
			sw_q <= !slow_en_i ? 4'h0 : sw_q + {3'h0, !sw_q[3]};
			ph_q <= ph_q + 5'h01;
		end
	end
	// Periods scaled down so the run stays short; no tick while stopped
	assign fast_tick_o = fast_en_i && ph_q[1:0] == 2'h0;
	assign slow_tick_o = slow_en_i && ph_q == 5'h00;
	assign fast_stable_o = fw_q[3];
	assign slow_stable_o = sw_q[3];
endmodule
`default_nettype wire

// [tb/test_system_clock_mode_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_mode_control
	import sclk_pkg::*;
;
	logic       clk_sys_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic       ce_i = 1'b1;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       halt_i = 1'b0;
	logic       wake_i = 1'b0;
	logic       clr_wdt_i = 1'b0;
	logic       wdt_timeout_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic       fast_tick_i, slow_tick_i, fast_osc_stable_i, slow_osc_stable_i, irq_o;
	sclk_clk_s  clk_o;
	sclk_ctl_s  ctl_o;
	sclk_mode_e mode_o;
	int         bad_count = 0;
	int         cmp_count = 0;
	always #20 clk_sys_i = !clk_sys_i;
	sclk_ctrl uut (.*);
	scmc_osc_model osc (.clk_sys_i, .rst_b_i, .fast_en_i(ctl_o.fast_osc_en),
		.slow_en_i(ctl_o.slow_osc_en), .fast_tick_o(fast_tick_i), .slow_tick_o(slow_tick_i),
		.fast_stable_o(fast_osc_stable_i), .slow_stable_o(slow_osc_stable_i));
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task pulse_halt(input logic h);
		@(posedge clk_sys_i);
		if (h) halt_i <= 1'b1; else wake_i <= 1'b1;
		@(posedge clk_sys_i);
		halt_i <= 1'b0;
		wake_i <= 1'b0;
		@(negedge clk_sys_i);
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("rdata", rdata_o, e);
	endtask
	task wt_fast(input logic v);
		int i;
		for (i = 0; i < 200 && ctl_o.fast_osc_en !== v; i++)
			@(negedge clk_sys_i);
		chk("fast_osc_en", ctl_o.fast_osc_en, v);
		if (i == 200) give_verdict;
	endtask
	// Measure between the second and third enables, the first may be cut short
	task div_meas(input logic [7:0] m, input int e);
		int n;
		int k;
		wr(SCLK_OFF_MODE, m);
		n = 0;
		k = 0;
		for (int i = 0; i < 1000 && k < 3; i++)
		begin
			@(negedge clk_sys_i);
			if (k == 2 && fast_tick_i) n++;
			if (clk_o.sys_clk_en) k++;
		end
		chk("divider", n[7:0], e[7:0]);
		if (k < 3) give_verdict;
	endtask
	task t_regs;
		cyc(20);
		rd(SCLK_OFF_MODE, 8'hee);
		rd(SCLK_OFF_CTRL, 8'h00);
		rd(SCLK_OFF_WDTKEY, 8'h50);
		wr(SCLK_OFF_MODE, 8'hff);
		rd(SCLK_OFF_MODE, 8'hef);
		wr(SCLK_OFF_CTRL, 8'hff);
		rd(SCLK_OFF_CTRL, 8'h87);
		wr(3'h6, 8'hff);
		rd(3'h6, 8'h00);
	endtask
	task t_slow;
		wr(SCLK_OFF_MODE, 8'h20);
		wt_fast(1'b0);
		repeat (64)
		begin
			@(negedge clk_sys_i);
			chk("sub_sys_clk", clk_o.sys_clk_en, slow_tick_i);
		end
		wr(SCLK_OFF_MODE, 8'he0);
		wt_fast(1'b1);
		cyc(20);
		rd(SCLK_OFF_MODE, 8'hec);
	endtask
	task t_halt(input logic [7:0] m, input logic [7:0] c, input logic [7:0] k, input sclk_mode_e e);
		wr(SCLK_OFF_MODE, m);
		wr(SCLK_OFF_CTRL, c);
		wr(SCLK_OFF_WDTKEY, k);
		pulse_halt(1'b1);
		chk("mode", mode_o, e);
		chk("wdt_clear", ctl_o.wdt_clear, 1'b1);
		chk("cpu_run", ctl_o.cpu_run, 1'b0);
		rd(SCLK_OFF_PWRSTAT, 8'h02);
		chk("irq", irq_o, 1'b1);
		pulse_halt(1'b0);
		cyc(40);
		chk("mode_run", mode_o, SCLK_RUN);
	endtask
	// Time-out wake, watchdog clear, frozen enable and a bad key
	task t_misc;
		pulse_halt(1'b1);
		@(posedge clk_sys_i);
		wdt_timeout_i <= 1'b1;
		@(posedge clk_sys_i);
		wdt_timeout_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("mode_wake", mode_o, SCLK_RUN);
		rd(SCLK_OFF_PWRSTAT, 8'h03);
		@(posedge clk_sys_i);
		clr_wdt_i <= 1'b1;
		@(posedge clk_sys_i);
		clr_wdt_i <= 1'b0;
		rd(SCLK_OFF_PWRSTAT, 8'h01);
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		wr(SCLK_OFF_CTRL, 8'h81);
		@(posedge clk_sys_i);
		ce_i <= 1'b1;
		rd(SCLK_OFF_CTRL, 8'h00);
		wr(SCLK_OFF_WDTKEY, 8'h18);
		@(negedge clk_sys_i);
		chk("key_bad", ctl_o.wdt_key_bad, 1'b1);
		wr(SCLK_OFF_WDTKEY, 8'h50);
		@(negedge clk_sys_i);
		chk("key_ok", ctl_o.wdt_key_bad, 1'b0);
	endtask
	initial
	begin
		cyc(3);
		rst_b_i <= 1'b1;
		t_regs;
		for (int c = 2; c < 8; c++)
			div_meas({c[2:0], 5'h00}, 1 << (8 - c));
		div_meas(8'h01, 1);
		t_slow;
		wr(SCLK_OFF_IRQMASK, 8'h01);
		t_halt(8'he3, 8'h00, 8'h50, SCLK_IDLE_CLOCK_OFF_MODE);
		t_halt(8'he3, 8'h80, 8'h50, SCLK_IDLE_CLOCK_ON_MODE);
		t_halt(8'he1, 8'h00, 8'ha8, SCLK_SLEEP_ALL_OFF_MODE);
		t_halt(8'he1, 8'h00, 8'h50, SCLK_SLEEP_WDT_ON_MODE);
		t_misc;
		wr(SCLK_OFF_IRQMASK, 8'h00);
		@(negedge clk_sys_i);
		chk("irq_masked", irq_o, 1'b0);
		wr(SCLK_OFF_IRQSTAT, 8'h01);
		wr(SCLK_OFF_IRQMASK, 8'h01);
		@(negedge clk_sys_i);
		chk("irq_cleared", irq_o, 1'b0);
		give_verdict;
	end
endmodule
`default_nettype wire
